// >>> mmt_map.svh
// Address map, field positions, reset values and timing counts of the module management block.
//
// Functional notes
// (RL1) Management initialisation completes within 2000 ms of power-on, plug or reset release.
// (RL2) Host holds module reset low at least 10 us; shorter pulses may reset.
// (RL3) Interrupt pin goes low within 200 ms of an interrupting condition.
// (RL4) Flags clear on read; interrupt pin releases within 500 us afterwards.
// (RL5) Receive signal loss sets its flag and pulls interrupt low within 100 ms.
// (RL6) Transmit fault sets its flag and pulls interrupt low within 200 ms.
// (RL7) Any other condition sets its flag and pulls interrupt low within 200 ms.
// (RL8) Setting a mask bit stops its flag pulling interrupt low within 100 ms.
// (RL9) Clearing a mask bit lets its flag pull interrupt low within 100 ms.
// (RL10) Management bus answers no later than 2 s after power-on.
// (RL11) Within 2 s of power-on, data-not-ready clears and interrupt goes low.
// (RL12) Fully functional within 2 s of the module reset rising edge.
// (RL13) Fully functional within 2 s of power-on when low power is not requested.
// (RL14) Low-power / transmit-disable pin mode switch completes within 100 ms.
// (RL15) Low power select released high brings power to class 1 within 100 ms.
// (RL16) Low power select pulled low gives full function within 300 ms.
// (RL17) Interrupt / receive-loss pin mode switch completes within 100 ms.
// (RL18) Power override or set bit: class 1 within 100 ms; cleared, functional within 300 ms.
// (RL19) Millisecond limits are timed by counters on a millisecond tick from the local clock; the reset low minimum is counted in clock cycles.
`ifndef MMT_MAP_SVH
`define MMT_MAP_SVH

// ==========================================================================
// Register offsets
`define MMT_ADDR_STATUS   8'h02
`define MMT_ADDR_FLAGS    8'h03
`define MMT_ADDR_MASK     8'h04
`define MMT_ADDR_CTRL     8'h05

// ==========================================================================
// Field positions
`define MMT_ST_NOT_READY  0
`define MMT_ST_MGMT_RDY   1
`define MMT_ST_FULL       2
`define MMT_ST_LOW_PWR    3
`define MMT_FL_RX_LOSS    0
`define MMT_FL_TX_FAULT   1
`define MMT_FL_OTHER      2
`define MMT_FL_DATA_RDY   3
`define MMT_CT_OVERRIDE   0
`define MMT_CT_POWER_SET  1
`define MMT_CT_LPS_TRANSMIT_DISABLE  2
`define MMT_CT_INT_RXLOSS 3

// ==========================================================================
// Reset values
`define MMT_RST_MASK      4'h0
`define MMT_RST_CTRL      4'h0

// ==========================================================================
// Timing
`define MMT_CLK_NS        4
`define MMT_MS_NS         1000000
`define MMT_MS_CYC        (`MMT_MS_NS / `MMT_CLK_NS)
`define MMT_RST_MIN_NS    10000
`define MMT_RST_MIN_CYC   ((`MMT_RST_MIN_NS + `MMT_CLK_NS - 1) / `MMT_CLK_NS)
`define MMT_INIT_MS       2000
`define MMT_LP_ON_MS      100
`define MMT_LP_OFF_MS     300
`define MMT_PD_ON_MS      100
`define MMT_PD_OFF_MS     300

`endif

// >>> mmt_pkg.sv
// Types shared by the module management block.
package mmt_pkg;

	// ======================================================================
	// Power and initialisation states
	typedef enum logic [2:0] {
		MMT_INIT,
		MMT_LOW,
		MMT_RAMP_UP,
		MMT_FULL,
		MMT_RAMP_DOWN
	} mmt_pwr_t;

	// ======================================================================
	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} mmt_req_t;

	// ======================================================================
	// Pins and conditions that cross into the clock domain
	typedef struct packed {
		logic reset_n;
		logic lps;
		logic rx_loss;
		logic tx_fault;
		logic other;
	} mmt_pins_t;

	// ======================================================================
	// Whole block state
	typedef struct packed {
		mmt_pins_t  s1;
		mmt_pins_t  s2;
		logic [11:0] rst_cnt;
		logic        mod_rst;
		logic [31:0] div_cnt;
		logic        ms_tick;
		logic [15:0] tmr;
		mmt_pwr_t    pwr;
		logic        not_ready;
		logic [3:0]  flags;
		logic [3:0]  mask;
		logic [3:0]  ctrl;
		logic        lps_transmit_disable;
		logic        int_rxloss;
		logic [7:0]  rdata;
		logic        irq;
		logic        pin_oe;
		logic        transmit_disable;
		logic        low_pwr;
		logic        full;
		logic        mgmt_rdy;
	} mmt_state_t;

endpackage : mmt_pkg

// >>> mmt_ctrl.sv
// Management timing, flag and power control of the module end.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "mmt_map.svh"

module mmt_ctrl #(
	parameter int unsigned MS_CYCLES = `MMT_MS_CYC,
	parameter int unsigned INIT_MS   = `MMT_INIT_MS,
	parameter int unsigned DOWN_MS   = `MMT_LP_ON_MS,
	parameter int unsigned UP_MS     = `MMT_LP_OFF_MS
) (
	input  wire logic              clk_sys_in,
	input  wire logic              nrst_in,
	input  wire mmt_pkg::mmt_req_t reg_req_in,
	output logic [7:0]             reg_rdata_out,
	input  wire logic              module_reset_n_in,
	input  wire logic              low_power_select_in,
	input  wire logic              rx_signal_loss_in,
	input  wire logic              tx_fault_in,
	input  wire logic              other_cond_in,
	output logic                   interrupt_n_out,
	output logic                   interrupt_n_oe_out,
	output logic                   transmit_disable_out,
	output logic                   low_power_out,
	output logic                   full_function_out,
	output logic                   mgmt_ready_out,
	output logic                   irq_out
);

	// ======================================================================
	// Helpers
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction : hit

	// A wait of lim ms ends one tick early, because the first tick comes after
	// an unknown fraction of a millisecond; the elapsed time never reaches lim.
	function automatic logic due(input logic [15:0] t, input logic [15:0] lim);
		due = ((t + 16'h0001) >= (lim - 16'h0001));
	endfunction : due

	localparam logic [31:0] MS_LAST  = 32'(MS_CYCLES - 1);
	localparam logic [15:0] INIT_LIM = 16'(INIT_MS);
	localparam logic [15:0] DOWN_LIM = 16'(DOWN_MS);
	localparam logic [15:0] UP_LIM   = 16'(UP_MS);
	localparam logic [11:0] RST_CYC  = 12'(`MMT_RST_MIN_CYC);

	mmt_pkg::mmt_state_t q;
	mmt_pkg::mmt_state_t d;
	mmt_pkg::mmt_state_t rst_val;

	mmt_pkg::mmt_pins_t pins;
	logic               want_low;
	logic [3:0]         ev;
	logic [3:0]         clr;
	logic [7:0]         status;

	assign pins = '{reset_n:  module_reset_n_in,
	                lps:      low_power_select_in,
	                rx_loss:  rx_signal_loss_in,
	                tx_fault: tx_fault_in,
	                other:    other_cond_in};

	// ======================================================================
	// Reset image
	always_comb begin
		rst_val            = '0;
		rst_val.s1         = '{reset_n: 1'b1, default: 1'b0};
		rst_val.s2         = '{reset_n: 1'b1, default: 1'b0};
		rst_val.pwr        = mmt_pkg::MMT_INIT;
		rst_val.not_ready  = 1'b1;
		rst_val.mask       = `MMT_RST_MASK;
		rst_val.ctrl       = `MMT_RST_CTRL;
		rst_val.pin_oe     = 1'b0;
	end

	// ======================================================================
	// Next state
	always_comb begin
		d = q;

		// Pins pass two flops; only the second stage is read.
		d.s1 = pins;
		d.s2 = q.s1;

		// Millisecond timebase.
		d.ms_tick = 1'b0;
		if (q.div_cnt >= MS_LAST) begin
			d.div_cnt = '0;
			d.ms_tick = 1'b1; // RL19
		end else begin
			d.div_cnt = q.div_cnt + 32'h0000_0001;
		end

		// Module reset pin: a low of 10 us is always honoured.
		if (q.s2.reset_n) begin
			d.rst_cnt = '0;
			d.mod_rst = 1'b0;
		end else if (q.rst_cnt >= RST_CYC - 12'h001) begin
			d.mod_rst = 1'b1; // RL2
		end else begin
			d.rst_cnt = q.rst_cnt + 12'h001;
		end

		// Modes of the dual-use pins are taken over on the millisecond tick.
		if (q.ms_tick) begin
			d.lps_transmit_disable  = q.ctrl[`MMT_CT_LPS_TRANSMIT_DISABLE]; // RL14
			d.int_rxloss = q.ctrl[`MMT_CT_INT_RXLOSS]; // RL17
		end

		want_low = q.ctrl[`MMT_CT_OVERRIDE] | q.ctrl[`MMT_CT_POWER_SET] // RL18
		         | (~q.lps_transmit_disable & q.s2.lps); // RL15

		// Power and initialisation sequencing.
		if (q.ms_tick) begin
			d.tmr = q.tmr + 16'h0001;
		end
		case (q.pwr)
			mmt_pkg::MMT_INIT: begin
				if (q.ms_tick && due(q.tmr, INIT_LIM)) begin
					d.tmr       = '0;
					d.not_ready = 1'b0; // RL11
					d.pwr       = want_low ? mmt_pkg::MMT_LOW : mmt_pkg::MMT_FULL; // RL1 RL12 RL13
				end
			end
			mmt_pkg::MMT_LOW: begin
				d.tmr = '0;
				if (!want_low) begin
					d.pwr = mmt_pkg::MMT_RAMP_UP;
				end
			end
			mmt_pkg::MMT_RAMP_UP: begin
				if (want_low) begin
					d.tmr = '0;
					d.pwr = mmt_pkg::MMT_RAMP_DOWN;
				end else if (q.ms_tick && due(q.tmr, UP_LIM)) begin
					d.tmr = '0;
					d.pwr = mmt_pkg::MMT_FULL; // RL16 RL18
				end
			end
			mmt_pkg::MMT_FULL: begin
				d.tmr = '0;
				if (want_low) begin
					d.pwr = mmt_pkg::MMT_RAMP_DOWN;
				end
			end
			mmt_pkg::MMT_RAMP_DOWN: begin
				if (!want_low) begin
					d.tmr = '0;
					d.pwr = mmt_pkg::MMT_RAMP_UP;
				end else if (q.ms_tick && due(q.tmr, DOWN_LIM)) begin
					d.tmr = '0;
					d.pwr = mmt_pkg::MMT_LOW; // RL15 RL18
				end
			end
			default: begin
				d.tmr = '0;
				d.pwr = mmt_pkg::MMT_INIT;
			end
		endcase

		// Flag events, sampled on the millisecond tick so a flag follows its
		// condition within one millisecond.
		ev = '0;
		if (q.ms_tick) begin
			ev[`MMT_FL_RX_LOSS]  = q.s2.rx_loss; // RL5
			ev[`MMT_FL_TX_FAULT] = q.s2.tx_fault; // RL6
			ev[`MMT_FL_OTHER]    = q.s2.other; // RL7
		end
		ev[`MMT_FL_DATA_RDY] = (q.pwr == mmt_pkg::MMT_INIT) && (d.pwr != mmt_pkg::MMT_INIT);

		// Register port.
		status = '0;
		status[`MMT_ST_NOT_READY] = q.not_ready;
		status[`MMT_ST_MGMT_RDY]  = q.mgmt_rdy;
		status[`MMT_ST_FULL]      = q.full;
		status[`MMT_ST_LOW_PWR]   = q.low_pwr;

		clr     = '0;
		d.rdata = '0;
		if (reg_req_in.rd) begin
			if (hit(reg_req_in.addr, `MMT_ADDR_STATUS)) begin
				d.rdata = status;
			end else if (hit(reg_req_in.addr, `MMT_ADDR_FLAGS)) begin
				d.rdata = {4'h0, q.flags};
				clr     = q.flags; // RL4
			end else if (hit(reg_req_in.addr, `MMT_ADDR_MASK)) begin
				d.rdata = {4'h0, q.mask};
			end else if (hit(reg_req_in.addr, `MMT_ADDR_CTRL)) begin
				d.rdata = {4'h0, q.ctrl};
			end
		end
		if (reg_req_in.wr) begin
			if (hit(reg_req_in.addr, `MMT_ADDR_FLAGS)) begin
				clr = reg_req_in.wdata[3:0];
			end else if (hit(reg_req_in.addr, `MMT_ADDR_MASK)) begin
				d.mask = reg_req_in.wdata[3:0]; // RL8 RL9
			end else if (hit(reg_req_in.addr, `MMT_ADDR_CTRL)) begin
				d.ctrl = reg_req_in.wdata[3:0];
			end
		end

		// A new event wins over a clear in the same cycle.
		d.flags = (q.flags & ~clr) | ev;

		// Outputs, all registered; a mask change or a clear acts next cycle.
		d.irq      = |(d.flags & ~d.mask); // RL3 RL8 RL9
		// Pin levels are taken from the second sync stage only; the first may be metastable.
		d.pin_oe   = d.int_rxloss ? q.s2.rx_loss : d.irq; // RL4 RL17
		d.transmit_disable    = d.lps_transmit_disable & q.s2.lps; // RL14
		d.low_pwr  = (d.pwr == mmt_pkg::MMT_LOW);
		d.full     = (d.pwr == mmt_pkg::MMT_FULL);
		d.mgmt_rdy = (d.pwr != mmt_pkg::MMT_INIT); // RL10

		// A module reset holds everything but the pin stages and its own filter.
		if (q.mod_rst) begin
			d         = rst_val;
			d.s1      = pins;
			d.s2      = q.s1;
			d.rst_cnt = q.rst_cnt;
			d.mod_rst = q.s2.reset_n ? 1'b0 : 1'b1; // RL12
		end
	end

	// ======================================================================
	// State register
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			q <= rst_val;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_out        = q.rdata;
	assign interrupt_n_out      = 1'b0;
	assign interrupt_n_oe_out   = q.pin_oe;
	assign transmit_disable_out = q.transmit_disable;
	assign low_power_out        = q.low_pwr;
	assign full_function_out    = q.full;
	assign mgmt_ready_out       = q.mgmt_rdy;
	assign irq_out              = q.irq;

endmodule : mmt_ctrl

// >>> mmt_ctrl_chk.sv
// Concurrent checks on the ports of the management timing block.
`timescale 1ns/1ps
`include "mmt_map.svh"
// ======
// Checker
module mmt_ctrl_chk #(
	parameter int unsigned MS_CYCLES = 4,
	parameter int unsigned INIT_MS   = 4
) (
	input wire logic              clk_sys_in,
	input wire logic              nrst_in,
	input wire mmt_pkg::mmt_req_t reg_req_in,
	input wire logic              low_power_select_in,
	input wire logic              rx_signal_loss_in,
	input wire logic              tx_fault_in,
	input wire logic              other_cond_in,
	input wire logic              irq_out,
	input wire logic              transmit_disable_out,
	input wire logic              low_power_out,
	input wire logic              mgmt_ready_out
);
	// Limits scale with the tick, so a short simulation tick keeps them in reach.
	localparam int INIT_CYC = (INIT_MS + 2) * MS_CYCLES + 8;
	localparam int LOS_CYC  = 100 * MS_CYCLES;
	localparam int FLG_CYC  = 200 * MS_CYCLES;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	sequence s_quiet;
		(!rx_signal_loss_in && !tx_fault_in && !other_cond_in && mgmt_ready_out)[*6];
	endsequence
	sequence s_flag_rd;
		reg_req_in.rd && reg_req_in.addr == `MMT_ADDR_FLAGS;
	endsequence
	sequence s_mask_wr;
		reg_req_in.wr && reg_req_in.addr == `MMT_ADDR_MASK;
	endsequence

	a_init_done: assert property ($rose(nrst_in) |-> ##[1:INIT_CYC] mgmt_ready_out)
		else $error("initialisation overran");
	a_flag_release: assert property (s_quiet ##0 s_flag_rd |-> ##[1:3] !irq_out)
		else $error("interrupt held after flag read");
	a_los_flag: assert property ($rose(rx_signal_loss_in) && mgmt_ready_out
		|-> ##[1:LOS_CYC] (irq_out || !rx_signal_loss_in || !mgmt_ready_out))
		else $error("signal loss not flagged");
	a_fault_flag: assert property ($rose(tx_fault_in) && mgmt_ready_out
		|-> ##[1:FLG_CYC] (irq_out || !tx_fault_in || !mgmt_ready_out))
		else $error("transmit fault not flagged");
	a_other_flag: assert property ($rose(other_cond_in) && mgmt_ready_out
		|-> ##[1:FLG_CYC] (irq_out || !other_cond_in || !mgmt_ready_out))
		else $error("condition not flagged");
	a_mask_stop: assert property (s_mask_wr ##0 reg_req_in.wdata[3:0] == 4'hf
		|-> ##[1:3] (!irq_out)[*4])
		else $error("masked flag still interrupts");
	a_mask_resume: assert property (s_mask_wr ##0 reg_req_in.wdata[3:0] == 4'h0
		&& rx_signal_loss_in && mgmt_ready_out |-> ##[1:LOS_CYC] irq_out)
		else $error("unmasked flag silent");
	a_low_power: assert property ($rose(low_power_select_in) && mgmt_ready_out
		|-> ##[1:LOS_CYC] (low_power_out || transmit_disable_out || !low_power_select_in))
		else $error("low power not reached");
endmodule : mmt_ctrl_chk

bind mmt_ctrl mmt_ctrl_chk #(.MS_CYCLES(MS_CYCLES), .INIT_MS(INIT_MS)) u_chk (.clk_sys_in,
	.nrst_in, .reg_req_in, .low_power_select_in, .rx_signal_loss_in, .tx_fault_in,
	.other_cond_in, .irq_out, .transmit_disable_out, .low_power_out, .mgmt_ready_out);

// >>> mmt_host_line.sv
// Host side of the open-drain interrupt line.
`timescale 1ns/1ps
// ======
// Line model
module mmt_host_line (
	input  wire logic int_oe_in,
	input  wire logic int_drv_in,
	output logic      int_line_out
);
	// The host pull-up sets the level whenever the module lets go of the line.
	assign int_line_out = int_oe_in ? int_drv_in : 1'b1;
endmodule : mmt_host_line

// >>> tb_top.sv
// Self-checking testbench of the module management block.
`timescale 1ns/1ps
// ======
// Bench
module tb_top;
	localparam int MS  = 4;
	localparam int INI = 4;
	logic              clk_sys_in = 1'b0;
	logic              nrst_in = 1'b0;
	mmt_pkg::mmt_req_t reg_req_in = '0;
	logic              module_reset_n_in = 1'b1;
	logic              low_power_select_in = 1'b0;
	logic              rx_signal_loss_in = 1'b0;
	logic              tx_fault_in = 1'b0;
	logic              other_cond_in = 1'b0;
	logic [7:0]        reg_rdata_out, got;
	logic              interrupt_n_out, interrupt_n_oe_out, transmit_disable_out;
	logic              low_power_out, full_function_out, mgmt_ready_out, irq_out, int_line;
	logic [2:0]        v;
	int                n_fail = 0;
	int                checks = 0;

	mmt_ctrl #(.MS_CYCLES(MS), .INIT_MS(INI), .DOWN_MS(2), .UP_MS(3)) i_mmt_ctrl (.clk_sys_in,
		.nrst_in, .reg_req_in, .reg_rdata_out, .module_reset_n_in, .low_power_select_in,
		.rx_signal_loss_in, .tx_fault_in, .other_cond_in, .interrupt_n_out, .interrupt_n_oe_out,
		.transmit_disable_out, .low_power_out, .full_function_out, .mgmt_ready_out, .irq_out);
	mmt_host_line i_mmt_host_line (.int_oe_in(interrupt_n_oe_out), .int_drv_in(interrupt_n_out),
		.int_line_out(int_line));

	initial begin
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	task automatic conclude;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	function automatic logic [7:0] exp_flags(input logic [2:0] c);
		return {5'h00, c};
	endfunction : exp_flags

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		reg_req_in <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk_sys_in);
		reg_req_in <= '0;
		#1 got = reg_rdata_out;
	endtask : bus

	task automatic ms(input int n);
		repeat (n * MS) @(posedge clk_sys_in);
	endtask : ms

	task automatic wait_rdy;
		for (int i = 0; i < (INI + 2) * MS && mgmt_ready_out !== 1'b1; i++)
			@(posedge clk_sys_in);
		chk({7'h0, mgmt_ready_out}, 8'h01);
		if (mgmt_ready_out !== 1'b1)
			conclude();
		ms(1);
	endtask : wait_rdy

	initial begin
		void'($urandom(69641));
		repeat (12) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		wait_rdy();
		chk({3'h0, int_line, mgmt_ready_out, full_function_out, low_power_out, irq_out}, 8'h0d);
		bus(1'b1, 8'h02, 8'hff);
		bus(1'b0, 8'h02, 8'h00);
		chk(got, 8'h06);
		bus(1'b0, 8'h04, 8'h00);
		chk(got, 8'h00);
		bus(1'b1, 8'h04, 8'h0f);
		ms(1);
		rx_signal_loss_in <= 1'b1;
		ms(3);
		chk({7'h0, int_line}, 8'h01);
		bus(1'b1, 8'h04, 8'h00);
		ms(1);
		chk({7'h0, int_line}, 8'h00);
		bus(1'b0, 8'h03, 8'h00);
		chk(got, 8'h09);
		ms(1);
		rx_signal_loss_in <= 1'b0;
		ms(2);
		bus(1'b0, 8'h03, 8'h00);
		repeat (2) @(posedge clk_sys_in);
		#1 chk({7'h0, int_line}, 8'h01);
		// Random reads of unmapped space are mixed in with the random conditions.
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys_in);
			v = 3'($urandom);
			{other_cond_in, tx_fault_in, rx_signal_loss_in} <= v;
			ms(3);
			bus(1'b0, 8'h03, 8'h00);
			ms(2);
			bus(1'b0, 8'h03, 8'h00);
			chk(got, exp_flags(v));
			bus(1'b0, 8'h10 | 8'($urandom), 8'h00);
			chk(got, 8'h00);
		end
		@(posedge clk_sys_in);
		{other_cond_in, tx_fault_in, rx_signal_loss_in} <= 3'h0;
		ms(2);
		bus(1'b0, 8'h03, 8'h00);
		for (int k = 0; k < 3; k++) begin
			if (k == 0)
				low_power_select_in <= 1'b1;
			else
				bus(1'b1, 8'h05, 8'(k));
			ms(4);
			chk({6'h0, low_power_out, full_function_out}, 8'h02);
			low_power_select_in <= 1'b0;
			bus(1'b1, 8'h05, 8'h00);
			ms(5);
			chk({6'h0, low_power_out, full_function_out}, 8'h01);
		end
		bus(1'b1, 8'h05, 8'h04);
		ms(2);
		low_power_select_in <= 1'b1;
		ms(4);
		chk({6'h0, transmit_disable_out, full_function_out}, 8'h03);
		low_power_select_in <= 1'b0;
		bus(1'b1, 8'h05, 8'h08);
		ms(2);
		rx_signal_loss_in <= 1'b1;
		ms(3);
		chk({6'h0, int_line, irq_out}, 8'h01);
		rx_signal_loss_in <= 1'b0;
		ms(1);
		chk({6'h0, int_line, irq_out}, 8'h03);
		// Only the receive-loss flag is left; a write of one must clear it without a read.
		bus(1'b1, 8'h03, 8'h01);
		bus(1'b0, 8'h03, 8'h00);
		chk(got, 8'h00);
		bus(1'b1, 8'h05, 8'h00);
		@(posedge clk_sys_in);
		module_reset_n_in <= 1'b0;
		repeat (2600) @(posedge clk_sys_in);
		chk({7'h0, mgmt_ready_out}, 8'h00);
		module_reset_n_in <= 1'b1;
		wait_rdy();
		conclude();
	end
endmodule : tb_top
